// >>> logic/sstu_store_unit.sv
module sstu_store_unit
   import sstu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmd_valid,
   input wire sstu_pkg::sstu_cmd_t cmd,
   output logic cmd_ready,
   output logic [4:0] gpr_rd_idx,
   input wire logic [31:0] gpr_rd_data,
   output sstu_pkg::sstu_mem_req_t mem_req,
   input wire sstu_pkg::sstu_mem_rsp_t mem_rsp,
   input wire logic resv_set,
   output logic resv,
   output sstu_pkg::sstu_wb_t wb,
   output sstu_pkg::sstu_cr_t condition_field_zero,
   output logic exc_illegal,
   output logic exc_align,
   output logic exc_mchk
);
   import sstu_pkg::*;

   // =========================================================
   // state
   typedef enum logic [2:0] {
      SSTU_IDLE, SSTU_FETCH, SSTU_LOAD, SSTU_STORE, SSTU_FINISH
   } sstu_state_t;

   sstu_state_t state;
   sstu_op_t op;
   logic [31:0] ctrl;
   logic [31:0] last_ea;
   logic [31:0] store_count;
   logic ill_seen, align_seen, mchk_seen;
   logic [31:0] ea;
   logic [31:0] start_ea;
   logic [4:0] cur_reg;
   logic [4:0] base_idx;
   logic [1:0] byte_pos;
   logic [6:0] left;
   logic [31:0] word;
   logic resv_start;
   logic so_bit;
   logic probe;
   logic done_cx;

   // =========================================================
   // effective address and decode
   logic [31:0] base_eff;
   logic [31:0] sext_disp;
   logic [31:0] cmd_ea;
   logic is_disp, is_index, is_upd, is_string;

   always_comb
   begin
      base_eff = (cmd.base_reg == 5'h00) ? 32'h0000_0000 : cmd.base_val;
      sext_disp = {{16{cmd.disp[15]}}, cmd.disp};
      is_disp = (cmd.op == SSTU_OP_HALF) || (cmd.op == SSTU_OP_HALF_UPD) ||
         (cmd.op == SSTU_OP_WORD) || (cmd.op == SSTU_OP_WORD_UPD) ||
         (cmd.op == SSTU_OP_MULTI);
      is_index = !is_disp && (cmd.op != SSTU_OP_STR_IMM);
      is_upd = (cmd.op == SSTU_OP_HALF_UPD) || (cmd.op == SSTU_OP_HALF_UX) ||
         (cmd.op == SSTU_OP_WORD_UPD) || (cmd.op == SSTU_OP_WORD_UX);
      is_string = (cmd.op == SSTU_OP_STR_IMM) || (cmd.op == SSTU_OP_STR_X);
      if (is_disp)
      begin
         cmd_ea = base_eff + sext_disp;
      end
      else if (is_index)
      begin
         cmd_ea = base_eff + cmd.index_val;
      end
      else
      begin
         cmd_ea = base_eff;
      end
   end

   // byte counts of the string forms
   logic [6:0] cmd_count;
   always_comb
   begin
      if (cmd.op == SSTU_OP_STR_X)
      begin
         cmd_count = cmd.transfer_byte_count;
      end
      else if (cmd.byte_count_field == 5'h00)
      begin
         cmd_count = SSTU_STR_ZERO_COUNT;
      end
      else
      begin
         cmd_count = {2'h0, cmd.byte_count_field};
      end
   end

   // =========================================================
   // store data formatting, first byte in data[31:24]
   function automatic sstu_mem_req_t fmt(
      input sstu_op_t fop,
      input logic [31:0] src,
      input logic [1:0] pos,
      input logic [31:0] addr
   );
      sstu_mem_req_t r;
      r.valid = 1'b1;
      r.probe = 1'b0;
      r.effective_addr = addr;
      r.data = src;
      r.size = SSTU_SIZE_WORD;
      case (fop)
         SSTU_OP_HALF, SSTU_OP_HALF_UPD, SSTU_OP_HALF_X, SSTU_OP_HALF_UX:
         begin
            r.data = {src[15:0], 16'h0000};
            r.size = SSTU_SIZE_HALF;
         end
         SSTU_OP_HALF_REV:
         begin
            r.data = {src[7:0], src[15:8], 16'h0000};
            r.size = SSTU_SIZE_HALF;
         end
         SSTU_OP_WORD_REV:
         begin
            r.data = {src[7:0], src[15:8], src[23:16], src[31:24]};
         end
         SSTU_OP_STR_IMM, SSTU_OP_STR_X:
         begin
            r.data = {src[6'd31 - 6'(pos) * 6'd8 -: 8], 24'h000000};
            r.size = SSTU_SIZE_BYTE;
         end
         default:
         begin
            r.data = src;
         end
      endcase
      return r;
   endfunction : fmt

   // =========================================================
   // sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= SSTU_IDLE;
         op <= SSTU_OP_WORD;
         cmd_ready <= 1'b0;
         gpr_rd_idx <= 5'h00;
         mem_req <= '0;
         wb <= '0;
         condition_field_zero <= '0;
         exc_illegal <= 1'b0;
         exc_align <= 1'b0;
         exc_mchk <= 1'b0;
         ea <= 32'h0000_0000;
         start_ea <= 32'h0000_0000;
         cur_reg <= 5'h00;
         base_idx <= 5'h00;
         byte_pos <= 2'h0;
         left <= 7'h00;
         word <= 32'h0000_0000;
         resv_start <= 1'b0;
         so_bit <= 1'b0;
         probe <= 1'b0;
         store_count <= 32'h0000_0000;
      end
      else
      begin
         wb.valid <= 1'b0;
         condition_field_zero.valid <= 1'b0;
         exc_illegal <= 1'b0;
         exc_align <= 1'b0;
         exc_mchk <= 1'b0;
         case (state)
            SSTU_IDLE:
            begin
               cmd_ready <= ctrl[SSTU_CTRL_EN_BIT];
               if (cmd_valid && cmd_ready)
               begin
                  cmd_ready <= 1'b0;
                  op <= cmd.op;
                  ea <= cmd_ea;
                  start_ea <= cmd_ea;
                  cur_reg <= cmd.source_reg;
                  base_idx <= cmd.base_reg;
                  byte_pos <= 2'h0;
                  left <= cmd_count;
                  resv_start <= resv;
                  so_bit <= cmd.summary_ovf;
                  probe <= 1'b0;
                  if (is_upd && cmd.base_reg == 5'h00)
                  begin
                     exc_illegal <= 1'b1;
                  end
                  else if (cmd.op == SSTU_OP_WORD_COND && cmd_ea[1:0] != 2'h0)
                  begin
                     exc_align <= 1'b1;
                  end
                  else if (cmd.op == SSTU_OP_WORD_COND && !resv)
                  begin
                     state <= SSTU_FINISH;
                  end
                  else if (cmd.op == SSTU_OP_STR_X && cmd_count == 7'h00)
                  begin
                     // zero length: probe only, no precise faults
                     probe <= 1'b1;
                     mem_req.valid <= 1'b1;
                     mem_req.probe <= 1'b1;
                     mem_req.effective_addr <= cmd_ea;
                     mem_req.data <= 32'h0000_0000;
                     mem_req.size <= 3'h0;
                     state <= SSTU_STORE;
                  end
                  else
                  begin
                     state <= SSTU_FETCH;
                  end
               end
            end
            SSTU_FETCH:
            begin
               gpr_rd_idx <= cur_reg;
               state <= SSTU_LOAD;
            end
            SSTU_LOAD:
            begin
               word <= gpr_rd_data;
               mem_req <= fmt(op, gpr_rd_data, byte_pos, ea);
               state <= SSTU_STORE;
            end
            SSTU_STORE:
            begin
               if (mem_rsp.ready)
               begin
                  mem_req.valid <= 1'b0;
                  mem_req.probe <= 1'b0;
                  if (probe)
                  begin
                     exc_mchk <= mem_rsp.prot_ok && mem_rsp.cachable &&
                        mem_rsp.miss && mem_rsp.bus_err;
                     state <= SSTU_FINISH;
                  end
                  else if (op == SSTU_OP_MULTI)
                  begin
                     if (cur_reg == SSTU_LAST_REG)
                     begin
                        state <= SSTU_FINISH;
                     end
                     else
                     begin
                        cur_reg <= cur_reg + 5'h01;
                        ea <= ea + SSTU_WORD_STEP;
                        state <= SSTU_FETCH;
                     end
                  end
                  else if (op == SSTU_OP_STR_IMM || op == SSTU_OP_STR_X)
                  begin
                     if (left == 7'h01)
                     begin
                        state <= SSTU_FINISH;
                     end
                     else
                     begin
                        left <= left - 7'h01;
                        ea <= ea + 32'h0000_0001;
                        if (byte_pos == SSTU_LAST_BYTE)
                        begin
                           byte_pos <= 2'h0;
                           cur_reg <= cur_reg + 5'h01;
                           state <= SSTU_FETCH;
                        end
                        else
                        begin
                           byte_pos <= byte_pos + 2'h1;
                           mem_req <= fmt(op, word, byte_pos + 2'h1,
                              ea + 32'h0000_0001);
                        end
                     end
                  end
                  else
                  begin
                     state <= SSTU_FINISH;
                  end
               end
            end
            SSTU_FINISH:
            begin
               if (op == SSTU_OP_HALF_UPD || op == SSTU_OP_HALF_UX ||
                  op == SSTU_OP_WORD_UPD || op == SSTU_OP_WORD_UX)
               begin
                  wb.valid <= 1'b1;
                  wb.idx <= base_idx;
                  wb.value <= start_ea;
               end
               // other indexed and string forms leave condition field alone
               if (op == SSTU_OP_WORD_COND)
               begin
                  condition_field_zero.valid <= 1'b1;
                  condition_field_zero.lt <= 1'b0;
                  condition_field_zero.gt <= 1'b0;
                  condition_field_zero.eq <= resv_start;
                  condition_field_zero.so <= so_bit;
               end
               if (!probe)
               begin
                  store_count <= store_count + 32'h0000_0001;
               end
               state <= SSTU_IDLE;
            end
            default:
            begin
               state <= SSTU_IDLE;
            end
         endcase
      end
   end

   assign done_cx = (state == SSTU_FINISH) && (op == SSTU_OP_WORD_COND);

   // =========================================================
   // reservation bit, a new reservation wins over the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         resv <= 1'b0;
      end
      else if (resv_set)
      begin
         resv <= 1'b1;
      end
      else if (done_cx)
      begin
         resv <= 1'b0;
      end
   end

   // =========================================================
   // apb slave, answers in the first access cycle
   logic wr_hit;
   assign wr_hit = psel && penable && pready && pwrite;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable)
         begin
            case (paddr)
               SSTU_CTRL_OFS: prdata <= ctrl;
               SSTU_STAT_OFS:
               begin
                  prdata[SSTU_ST_BUSY_BIT] <= (state != SSTU_IDLE);
                  prdata[SSTU_ST_RESV_BIT] <= resv;
                  prdata[SSTU_ST_ILL_BIT] <= ill_seen;
                  prdata[SSTU_ST_ALIGN_BIT] <= align_seen;
                  prdata[SSTU_ST_MCHK_BIT] <= mchk_seen;
               end
               SSTU_LAST_EA_OFS: prdata <= last_ea;
               SSTU_COUNT_OFS: prdata <= store_count;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= SSTU_CTRL_RST;
      end
      else if (wr_hit && paddr == SSTU_CTRL_OFS)
      begin
         ctrl <= pwdata;
      end
   end

   // sticky fault flags, write one to clear, a new event wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ill_seen <= 1'b0;
         align_seen <= 1'b0;
         mchk_seen <= 1'b0;
      end
      else
      begin
         if (exc_illegal)
            ill_seen <= 1'b1;
         else if (wr_hit && paddr == SSTU_STAT_OFS && pwdata[SSTU_ST_ILL_BIT])
            ill_seen <= 1'b0;
         if (exc_align)
            align_seen <= 1'b1;
         else if (wr_hit && paddr == SSTU_STAT_OFS &&
            pwdata[SSTU_ST_ALIGN_BIT])
            align_seen <= 1'b0;
         if (exc_mchk)
            mchk_seen <= 1'b1;
         else if (wr_hit && paddr == SSTU_STAT_OFS &&
            pwdata[SSTU_ST_MCHK_BIT])
            mchk_seen <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         last_ea <= 32'h0000_0000;
      end
      else if (state == SSTU_FINISH)
      begin
         last_ea <= start_ea;
      end
   end

   // =========================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [31:0] acc_addr;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         acc_addr <= 32'h0000_0000;
      else if (mem_req.valid && mem_rsp.ready)
         acc_addr <= mem_req.effective_addr;
   end

   a_req_held_stable: assert property (
      mem_req.valid && !mem_rsp.ready |=>
         mem_req.valid && $stable(mem_req.effective_addr)
         && $stable(mem_req.data))
      else $error("store request changed before it was taken");
   a_multi_word_step: assert property (
      mem_req.valid && mem_rsp.ready && op == SSTU_OP_MULTI &&
         cur_reg != SSTU_LAST_REG |-> ##[1:3]
         (mem_req.valid && mem_req.effective_addr == acc_addr + 32'd4))
      else $error("store multiple address did not advance by four");
   a_string_byte_size: assert property (
      mem_req.valid && !mem_req.probe &&
         (op == SSTU_OP_STR_IMM || op == SSTU_OP_STR_X) |->
         mem_req.size == SSTU_SIZE_BYTE && mem_req.data[23:0] == 24'h0)
      else $error("string store not a single byte");
   a_cond_no_write: assert property (
      mem_req.valid && op == SSTU_OP_WORD_COND |-> resv_start)
      else $error("conditional store wrote without reservation");
   a_cr_field_value: assert property (
      condition_field_zero.valid |->
         !condition_field_zero.lt && !condition_field_zero.gt &&
         condition_field_zero.eq == $past(resv_start))
      else $error("condition field zero wrong after conditional store");
   a_resv_cleared_end: assert property (
      condition_field_zero.valid && !$past(resv_set) |-> !resv)
      else $error("reservation still set after conditional store");
   a_align_fault_cond: assert property (
      cmd_valid && cmd_ready && cmd.op == SSTU_OP_WORD_COND &&
         cmd_ea[1:0] != 2'h0 |=> exc_align ##1 !mem_req.valid[*3])
      else $error("misaligned conditional store not faulted");
   a_update_wb_base: assert property (
      wb.valid |-> wb.idx != 5'h00 && wb.value == $past(start_ea))
      else $error("update written back to register zero or wrong value");
   a_zero_string_probe: assert property (
      cmd_valid && cmd_ready && cmd.op == SSTU_OP_STR_X &&
         cmd.transfer_byte_count == 7'h00 |=>
         mem_req.valid && mem_req.probe && !exc_align)
      else $error("zero length string store did not probe");

endmodule : sstu_store_unit

// >>> logic/sstu_pkg.sv
package sstu_pkg;

   // =========================================================
   // register map
   localparam logic [7:0] SSTU_CTRL_OFS = 8'h00;
   localparam logic [7:0] SSTU_STAT_OFS = 8'h04;
   localparam logic [7:0] SSTU_LAST_EA_OFS = 8'h08;
   localparam logic [7:0] SSTU_COUNT_OFS = 8'h0C;
   localparam int SSTU_CTRL_EN_BIT = 0;
   localparam logic [31:0] SSTU_CTRL_RST = 32'h0000_0001;
   localparam int SSTU_ST_BUSY_BIT = 0;
   localparam int SSTU_ST_RESV_BIT = 1;
   localparam int SSTU_ST_ILL_BIT = 2;
   localparam int SSTU_ST_ALIGN_BIT = 3;
   localparam int SSTU_ST_MCHK_BIT = 4;

   // =========================================================
   // datapath constants
   localparam logic [6:0] SSTU_STR_ZERO_COUNT = 7'h20;
   localparam logic [31:0] SSTU_WORD_STEP = 32'h0000_0004;
   localparam logic [4:0] SSTU_LAST_REG = 5'h1F;
   localparam logic [1:0] SSTU_LAST_BYTE = 2'h3;
   localparam logic [2:0] SSTU_SIZE_BYTE = 3'h1;
   localparam logic [2:0] SSTU_SIZE_HALF = 3'h2;
   localparam logic [2:0] SSTU_SIZE_WORD = 3'h4;

   // =========================================================
   // types
   typedef enum logic [3:0] {
      SSTU_OP_HALF, SSTU_OP_HALF_UPD, SSTU_OP_HALF_X, SSTU_OP_HALF_UX,
      SSTU_OP_HALF_REV, SSTU_OP_WORD, SSTU_OP_WORD_UPD, SSTU_OP_WORD_X,
      SSTU_OP_WORD_UX, SSTU_OP_WORD_REV, SSTU_OP_WORD_COND,
      SSTU_OP_MULTI, SSTU_OP_STR_IMM, SSTU_OP_STR_X
   } sstu_op_t;

   typedef struct packed {
      sstu_op_t op;
      logic [4:0] source_reg;
      logic [4:0] base_reg;
      logic [31:0] base_val;
      logic [31:0] index_val;
      logic [15:0] disp;
      logic [4:0] byte_count_field;
      logic [6:0] transfer_byte_count;
      logic summary_ovf;
      logic rc_bit;
   } sstu_cmd_t;

   typedef struct packed {
      logic valid;
      logic probe;
      logic [31:0] effective_addr;
      logic [31:0] data;
      logic [2:0] size;
   } sstu_mem_req_t;

   typedef struct packed {
      logic ready;
      logic prot_ok;
      logic cachable;
      logic miss;
      logic bus_err;
   } sstu_mem_rsp_t;

   typedef struct packed {
      logic valid;
      logic [4:0] idx;
      logic [31:0] value;
   } sstu_wb_t;

   typedef struct packed {
      logic valid;
      logic lt;
      logic gt;
      logic eq;
      logic so;
   } sstu_cr_t;

endpackage : sstu_pkg

// >>> verif/sstu_mem_model.sv
module sstu_mem_model
   import sstu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire sstu_pkg::sstu_mem_req_t mem_req,
   input wire logic slow,
   input wire logic fault,
   output sstu_pkg::sstu_mem_rsp_t mem_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_cnt;
   // accept at once, or after three wait cycles when slow
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mem_rsp <= '0;
         wait_cnt <= 2'h0;
      end
      else
      begin
         mem_rsp.ready <= mem_req.valid && !mem_rsp.ready &&
            (!slow || wait_cnt == 2'h3);
         wait_cnt <= (mem_req.valid && !mem_rsp.ready) ? wait_cnt + 2'h1 :
            2'h0;
         // fault gives a cachable miss whose fill hits a bus error
         mem_rsp.prot_ok <= fault;
         mem_rsp.cachable <= fault;
         mem_rsp.miss <= fault;
         mem_rsp.bus_err <= fault;
      end
   end
endmodule : sstu_mem_model

// >>> verif/store_instruction_unit_tb_top.sv
module store_instruction_unit_tb_top;
   import sstu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, cmd_valid = 1'b0, resv_set = 1'b0;
   logic slow = 1'b0, fault = 1'b0, pslverr, pready, cmd_ready, resv;
   logic exc_illegal, exc_align, exc_mchk;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, gpr_rd_data;
   logic [4:0] gpr_rd_idx;
   sstu_cmd_t cmd = '0;
   sstu_mem_req_t mem_req;
   sstu_mem_rsp_t mem_rsp;
   sstu_wb_t wb, l_wb;
   sstu_cr_t condition_field_zero, l_cr;
   logic [31:0] q_ea[$], q_d[$];
   int n_errors = 0, n_checks = 0, cyc = 0;
   int n_wb = 0, n_ill = 0, n_al = 0, n_mc = 0;

   function automatic logic [31:0] gv(input logic [4:0] i);
      return {3'h5, i, 8'hC3, 8'h96, 3'h2, i};
   endfunction : gv
   assign gpr_rd_data = gv(gpr_rd_idx);
   always #2.5 pclk = ~pclk;

   sstu_store_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
      .gpr_rd_idx(gpr_rd_idx), .gpr_rd_data(gpr_rd_data),
      .mem_req(mem_req), .mem_rsp(mem_rsp), .resv_set(resv_set),
      .resv(resv), .wb(wb), .condition_field_zero(condition_field_zero),
      .exc_illegal(exc_illegal), .exc_align(exc_align),
      .exc_mchk(exc_mchk));
   sstu_mem_model u_mem (.pclk(pclk), .presetn(presetn),
      .mem_req(mem_req), .slow(slow), .fault(fault), .mem_rsp(mem_rsp));

   // =========================================================
   // monitors and tasks
   always @(posedge pclk)
   begin
      cyc++;
      if (mem_req.valid === 1'b1 && mem_rsp.ready === 1'b1 && !mem_req.probe)
      begin
         q_ea.push_back(mem_req.effective_addr);
         q_d.push_back(mem_req.data);
      end
      if (wb.valid === 1'b1) l_wb = wb;
      if (condition_field_zero.valid === 1'b1) l_cr = condition_field_zero;
      n_wb += int'(wb.valid === 1'b1);
      n_ill += int'(exc_illegal === 1'b1);
      n_al += int'(exc_align === 1'b1);
      n_mc += int'(exc_mchk === 1'b1);
      if (cyc == 20000)
      begin
         n_errors++;
         finish_test();
      end
   end

   task automatic finish_test;
      if (n_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic sstu_cmd_t mk(input sstu_op_t op, input logic [4:0] s,
      input logic [4:0] b, input logic [31:0] bv, input logic [31:0] iv,
      input logic [15:0] d, input logic [6:0] n);
      return '{op, s, b, bv, iv, d, n[4:0], n, 1'b0, 1'b0};
   endfunction : mk

   task automatic run(input sstu_cmd_t c);
      int t;
      for (t = 0; t < 300 && cmd_ready !== 1'b1; t++) @(negedge pclk);
      @(posedge pclk);
      cmd_valid <= 1'b1;
      cmd <= c;
      do @(posedge pclk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      @(negedge pclk);
      for (t = 0; t < 300 && cmd_ready !== 1'b1; t++) @(negedge pclk);
      repeat (2) @(negedge pclk);
   endtask : run

   task automatic req(input logic [31:0] ea, input logic [31:0] d,
      input logic [31:0] m);
      if (q_ea.size() == 0)
         chk(32'h0, 32'h1);
      else
      begin
         chk(q_ea.pop_front(), ea);
         chk(q_d.pop_front() & m, d & m);
      end
   endtask : req

   // =========================================================
   // main sequence
   initial
   begin
      logic [31:0] rd, g;
      logic er;
      sstu_cmd_t c;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, SSTU_CTRL_OFS, 32'h0, rd, er);
      chk(rd, SSTU_CTRL_RST);
      apb(1'b0, 8'h10, 32'h0, rd, er);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, SSTU_CTRL_OFS, 32'h0, rd, er);
      repeat (2) @(negedge pclk);
      chk({31'h0, cmd_ready}, 32'h0);
      apb(1'b1, SSTU_CTRL_OFS, 32'h1, rd, er);
      g = gv(5'h5);
      run(mk(SSTU_OP_HALF, 5'h5, 5'h2, 32'h1000, 32'h0, 16'hFFF0, 7'h0));
      req(32'h0FF0, {g[15:0], 16'h0}, 32'hFFFF0000);
      g = gv(5'h7);
      run(mk(SSTU_OP_HALF_REV, 5'h7, 5'h0, 32'hDEAD0000, 32'h200, 16'h0,
         7'h0));
      req(32'h200, {g[7:0], g[15:8], 16'h0}, 32'hFFFF0000);
      run(mk(SSTU_OP_WORD_UPD, 5'h9, 5'h3, 32'h100, 32'h0, 16'h8, 7'h0));
      req(32'h108, gv(5'h9), 32'hFFFFFFFF);
      chk({27'h0, l_wb.idx}, 32'h3);
      chk(l_wb.value, 32'h108);
      g = gv(5'hA);
      run(mk(SSTU_OP_WORD_REV, 5'hA, 5'h4, 32'h20, 32'h4, 16'h0, 7'h0));
      req(32'h24, {g[7:0], g[15:8], g[23:16], g[31:24]}, '1);
      @(posedge pclk) slow <= 1'b1;
      run(mk(SSTU_OP_MULTI, 5'h1E, 5'h1, 32'h40, 32'h0, 16'h0, 7'h0));
      req(32'h40, gv(5'h1E), '1);
      req(32'h44, gv(5'h1F), '1);
      chk(q_ea.size(), 0);
      run(mk(SSTU_OP_STR_IMM, 5'h1F, 5'h0, 32'h999, 32'h0, 16'h0, 7'h5));
      for (int k = 0; k < 5; k++)
      begin
         g = gv(k < 4 ? 5'h1F : 5'h0);
         req(k, {g[31 - 8 * (k % 4) -: 8], 24'h0}, 32'hFF000000);
      end
      @(posedge pclk) slow <= 1'b0;
      run(mk(SSTU_OP_STR_IMM, 5'h1, 5'h2, 32'h300, 32'h0, 16'h0, 7'h0));
      chk(q_ea.size(), 32);
      q_ea.delete();
      q_d.delete();
      run(mk(SSTU_OP_STR_X, 5'h0, 5'h1, 32'h10, 32'h1, 16'h0, 7'h3));
      chk(q_ea.size(), 3);
      g = gv(5'h0);
      req(32'h11, {g[31:24], 24'h0}, 32'hFF000000);
      q_ea.delete();
      q_d.delete();
      @(posedge pclk) fault <= 1'b1;
      run(mk(SSTU_OP_STR_X, 5'h0, 5'h1, 32'h10, 32'h3, 16'h0, 7'h0));
      chk(q_ea.size(), 0);
      chk(n_mc, 1);
      @(posedge pclk) resv_set <= 1'b1;
      @(posedge pclk) resv_set <= 1'b0;
      c = mk(SSTU_OP_WORD_COND, 5'h6, 5'h2, 32'h80, 32'h4, 16'h0, 7'h0);
      c.summary_ovf = 1'b1;
      run(c);
      req(32'h84, gv(5'h6), '1);
      chk({28'h0, l_cr.lt, l_cr.gt, l_cr.eq, l_cr.so}, 32'h3);
      chk({31'h0, resv}, 32'h0);
      run(c);
      chk(q_ea.size(), 0);
      chk({28'h0, l_cr.lt, l_cr.gt, l_cr.eq, l_cr.so}, 32'h1);
      @(posedge pclk) resv_set <= 1'b1;
      @(posedge pclk) resv_set <= 1'b0;
      run(mk(SSTU_OP_WORD_COND, 5'h6, 5'h2, 32'h80, 32'h2, 16'h0, 7'h0));
      chk(n_al, 1);
      run(mk(SSTU_OP_WORD_UPD, 5'h9, 5'h0, 32'h100, 32'h0, 16'h8, 7'h0));
      chk(n_ill, 1);
      chk(q_ea.size() + n_wb, 1);
      apb(1'b0, SSTU_STAT_OFS, 32'h0, rd, er);
      chk(rd, 32'h0000_001E);
      apb(1'b1, SSTU_STAT_OFS, 32'h0000_001C, rd, er);
      apb(1'b0, SSTU_STAT_OFS, 32'h0, rd, er);
      chk(rd, 32'h0000_0002);
      apb(1'b0, SSTU_COUNT_OFS, 32'h0, rd, er);
      chk(rd, 32'h0000_000A);
      apb(1'b0, SSTU_LAST_EA_OFS, 32'h0, rd, er);
      chk(rd, 32'h0000_0084);
      finish_test();
   end
endmodule : store_instruction_unit_tb_top
